// [core/drive_io_pkg.sv]
// Shared constants, register map and carrier types for drive I/O conditioning
package drive_io_pkg;

	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int HW_TICK_NS = 2000;
	localparam int HW_TICK_CYCLES = (HW_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SW_TICK_NS = 250000;
	localparam int SW_TICK_CYCLES = (SW_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int VEL_SMOOTH_HZ = 10;
	// 2*pi*10 Hz / 4 kHz update is close to 1/64
	localparam logic [3:0] VEL_SMOOTH_SHIFT = 4'h6;

	// Data width
	localparam int DATA_W = 16;

	// Register byte offsets
	localparam logic [7:0] REG_CTRL_OFS = 8'h00;
	localparam logic [7:0] REG_DIN_FUNC_OFS = 8'h04;
	localparam logic [7:0] REG_AIN_BIAS_OFS = 8'h08;
	localparam logic [7:0] REG_THRESHOLD_A_OFS = 8'h0C;
	localparam logic [7:0] REG_AIN_BREAK_OFS = 8'h10;
	localparam logic [7:0] REG_AIN_CUR_SCALE_OFS = 8'h14;
	localparam logic [7:0] REG_AIN_VEL_SCALE_OFS = 8'h18;
	localparam logic [7:0] REG_AOUT_SELECT_OFS = 8'h1C;
	localparam logic [7:0] REG_AOUT_USER_OFS = 8'h20;
	localparam logic [7:0] REG_AOUT_SCALE_OFS = 8'h24;
	localparam logic [7:0] REG_STATUS_OFS = 8'h28;
	localparam logic [7:0] REG_AIN_FILTERED_VALUE_OFS = 8'h2C;
	localparam logic [7:0] REG_AOUT_PRESENT_VOLTAGE_OFS = 8'h30;

	// Field positions
	localparam int CTRL_SW_EN_BIT = 0;
	localparam int CTRL_SW_PERM_BIT = 1;
	localparam int CTRL_SRC_LSB = 2;
	localparam int CTRL_OPMODE_LSB = 4;
	localparam int DIN_FUNC_W = 5;

	// Reset values
	localparam logic [5:0] CTRL_RST = 6'h00;
	localparam logic [24:0] DIN_FUNC_RST = 25'h0000000;
	localparam logic [15:0] BIAS_RST = 16'h0000;
	localparam logic [15:0] THRESHOLD_RST = 16'h0000;
	localparam logic [3:0] BREAK_RST = 4'h4;
	localparam logic [15:0] SCALE_RST = 16'h0100;
	localparam logic [3:0] AOUT_SELECT_RST = 4'h0;
	localparam logic [15:0] AOUT_USER_RST = 16'h0000;

	// Command source and operating mode codes
	localparam logic [1:0] CMD_SRC_ANALOG = 2'h3;
	localparam logic [1:0] OPMODE_CURRENT = 2'h0;
	localparam logic [1:0] OPMODE_VELOCITY = 2'h1;

	// Input function codes; stop and limit functions are low active
	localparam logic [4:0] FUNC_NONE = 5'h00;
	localparam logic [4:0] FUNC_CTRL_STOP = 5'h0D;
	localparam logic [4:0] FUNC_QUICK_STOP = 5'h0F;
	localparam logic [4:0] FUNC_POS_LIMIT = 5'h12;
	localparam logic [4:0] FUNC_NEG_LIMIT = 5'h13;

	// Analog output source codes
	localparam logic [3:0] AOUT_USER = 4'h0;
	localparam logic [3:0] AOUT_VEL_FB = 4'h1;
	localparam logic [3:0] AOUT_VEL_ERR = 4'h2;
	localparam logic [3:0] AOUT_VEL_CMD = 4'h3;
	localparam logic [3:0] AOUT_CUR_ACT = 4'h4;
	localparam logic [3:0] AOUT_CUR_CMD = 4'h5;
	localparam logic [3:0] AOUT_POS_ACT = 4'h6;
	localparam logic [3:0] AOUT_POS_ERR = 4'h7;
	localparam logic [3:0] AOUT_TRIANGLE = 4'h8;
	localparam logic [3:0] AOUT_DEBUG = 4'h9;
	localparam logic [3:0] AOUT_VEL_RAW = 4'hA;
	localparam logic [3:0] AOUT_VEL_SMOOTH = 4'hB;

	// Triangle generator
	localparam logic signed [15:0] TRI_STEP = 16'sh0100;
	localparam logic signed [15:0] TRI_PEAK = 16'sh7F00;
	localparam logic signed [15:0] TRI_TROUGH = -16'sh7F00;

	typedef enum logic {TRI_UP = 1'b0, TRI_DOWN = 1'b1} tri_dir_t;

	typedef struct packed {
		logic [1:0] opmode;
		logic [1:0] cmd_source;
		logic sw_enable_permanent;
		logic sw_enable;
	} ctrl_t;

	typedef struct packed {
		logic signed [15:0] velocity_feedback;
		logic signed [15:0] velocity_error;
		logic signed [15:0] velocity_command;
		logic signed [15:0] current_actual;
		logic signed [15:0] current_command;
		logic signed [15:0] position_actual;
		logic signed [15:0] position_error;
		logic signed [15:0] velocity_feedback_raw;
	} drive_signals_t;

endpackage

// [core/ain_lowpass.sv]
// First-order low-pass filter with a shift-selected break point
`timescale 1ns/1ps
`default_nettype none
module ain_lowpass #(
	parameter int W = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic step_i,
	input wire logic [3:0] shift_i,
	input wire logic signed [W-1:0] x_i,
	output logic signed [W-1:0] y_o
);
	logic signed [W+15:0] acc_reg;
	logic signed [W+16:0] diff;

	// Error between input and state, with 16 fraction bits
	always_comb begin
		diff = (W+17)'($signed({x_i, 16'h0000})) - (W+17)'(acc_reg); // Keep the sign of x
	end

	// State moves by the error scaled down by 2^shift
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			acc_reg <= '0;
		end else if (step_i) begin
			acc_reg <= acc_reg + (W+16)'(diff >>> shift_i);
		end
	end

	assign y_o = acc_reg[W+15:16];
endmodule // ain_lowpass
`default_nettype wire

// [core/drive_io_conditioning.sv]
// Digital input sampling, output stage enable and analog I/O conditioning
//
// Notes on behaviour
// - Eight digital inputs; input eight is fixed to the output stage enable.
// - Inputs one and two are sampled by hardware every 2 us.
// - Inputs three to seven are sampled on the 250 us software tick.
// - After reset inputs three to seven have no function and trigger nothing.
// - Active level of each configurable input follows its assigned function.
// - Output stage enabled only with enable input high and safe torque off asserted.
// - Hardware enable is ANDed with a software enable that may be permanent.
// - Enable input low keeps the output stage disabled, no torque.
// - Analog input drives loop commands only when analog source is selected.
// - A configurable bias is added to the sampled analog input.
// - A configurable deadband suppresses noise at standstill.
// - Analog input is low-pass filtered with a configurable break point.
// - Readable value reports input after bias, deadband and filter.
// - Current mode scales by current per volt, velocity mode by velocity per volt.
// - Output select codes 1 to 7 and 10 pick the listed drive signals.
// - Output select zero presents the user written value.
// - Output scale factor applies only to select codes one, two and three.
// - Output select eight produces an internal triangle wave.
// - Output select nine routes a user chosen debug variable.
// - Output select eleven gives velocity feedback through a 10 Hz low-pass.
// - Readable value reports the voltage presently on the analog output.
//
// The address map and the Wishbone register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module drive_io_conditioning
	import drive_io_pkg::*;
#(
	parameter int SW_TICK_LEN = SW_TICK_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [7:0] din_i,
	input wire logic safe_torque_off_in_i,
	input wire logic signed [15:0] ain_sample_i,
	input wire drive_signals_t drive_i,
	input wire logic [3:0][15:0] debug_vars_i,
	output logic [1:0] fast_din_o,
	output logic [4:0] din_func_active_o,
	output logic stage_enable_o,
	output logic cmd_valid_o,
	output logic signed [15:0] current_command_o,
	output logic signed [15:0] velocity_command_o,
	output logic signed [15:0] ain_filtered_value_o,
	output logic signed [15:0] aout_present_voltage_o
);
	localparam int SW_CNT_W = $clog2(SW_TICK_LEN);

	////////////////////////////////////////////////////////////////////////////
	// Helper functions

	// Clamp a wide signed value into 16 bits
	function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
		if (v > 32'sd32767) begin
			return 16'sh7FFF;
		end else if (v < -32'sd32768) begin
			return 16'sh8000;
		end
		return v[15:0];
	endfunction

	// Multiply by an 8.8 fixed point factor
	function automatic logic signed [15:0] scale_q8(input logic signed [15:0] x,
			input logic signed [15:0] k);
		logic signed [31:0] p;
		p = x * k;
		return sat16(p >>> 8);
	endfunction

	// Byte-lane merge of a Wishbone write
	function automatic logic [31:0] wb_merge(input logic [31:0] old, input logic [31:0] d,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Functions that act on a low input level
	function automatic logic func_low_active(input logic [4:0] f);
		return (f == FUNC_CTRL_STOP) || (f == FUNC_QUICK_STOP) ||
			(f == FUNC_POS_LIMIT) || (f == FUNC_NEG_LIMIT);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Registers

	ctrl_t ctrl_reg;
	logic [4:0][4:0] din_function_reg;
	logic signed [15:0] ain_bias_reg;
	logic [15:0] threshold_a_reg;
	logic [3:0] ain_lowpass_break_reg;
	logic signed [15:0] ain_current_per_volt_reg;
	logic signed [15:0] ain_velocity_per_volt_reg;
	logic [3:0] aout_source_select_reg;
	logic signed [15:0] aout_user_value_reg;
	logic signed [15:0] aout_scale_factor_reg;
	logic [31:0] rd_word;
	logic [31:0] wr_word;
	logic [31:0] wb_dat_reg;
	logic wb_ack_reg;
	logic wb_req;

	logic [6:0] hw_cnt_reg;
	logic hw_tick_reg;
	logic [SW_CNT_W-1:0] sw_cnt_reg;
	logic sw_tick_reg;
	logic [1:0] fast_din_reg;
	logic [4:0] slow_din_reg;
	logic [4:0] din_func_reg;
	logic enable_in_reg;
	logic stage_enable_reg;
	logic signed [15:0] biased;
	logic signed [16:0] biased_wide;
	logic signed [16:0] biased_mag;
	logic signed [15:0] deadbanded;
	logic signed [15:0] ain_lp;
	logic signed [15:0] vel_smooth;
	logic signed [15:0] ain_filtered_value_reg;
	logic cmd_valid_reg;
	logic signed [15:0] current_cmd_reg;
	logic signed [15:0] velocity_cmd_reg;
	tri_dir_t tri_dir_reg;
	logic signed [15:0] tri_reg;
	logic signed [15:0] aout_next;
	logic signed [15:0] aout_reg;

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	assign wb_req = wb_cyc_i && wb_stb_i;

	// Read view of the map, unmapped reads as zero
	always_comb begin
		rd_word = 32'h00000000;
		case (wb_adr_i)
			REG_CTRL_OFS: rd_word = 32'(ctrl_reg);
			REG_DIN_FUNC_OFS: rd_word = 32'(din_function_reg);
			REG_AIN_BIAS_OFS: rd_word = {16'h0000, ain_bias_reg};
			REG_THRESHOLD_A_OFS: rd_word = {16'h0000, threshold_a_reg};
			REG_AIN_BREAK_OFS: rd_word = {28'h0000000, ain_lowpass_break_reg};
			REG_AIN_CUR_SCALE_OFS: rd_word = {16'h0000, ain_current_per_volt_reg};
			REG_AIN_VEL_SCALE_OFS: rd_word = {16'h0000, ain_velocity_per_volt_reg};
			REG_AOUT_SELECT_OFS: rd_word = {28'h0000000, aout_source_select_reg};
			REG_AOUT_USER_OFS: rd_word = {16'h0000, aout_user_value_reg};
			REG_AOUT_SCALE_OFS: rd_word = {16'h0000, aout_scale_factor_reg};
			REG_STATUS_OFS: rd_word = {18'h00000, stage_enable_reg, din_func_reg,
				slow_din_reg, fast_din_reg, enable_in_reg};
			REG_AIN_FILTERED_VALUE_OFS: rd_word = {16'h0000, ain_filtered_value_reg};
			REG_AOUT_PRESENT_VOLTAGE_OFS: rd_word = {16'h0000, aout_reg};
			default: rd_word = 32'h00000000;
		endcase
	end

	assign wr_word = wb_merge(rd_word, wb_dat_i, wb_sel_i);

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h00000000;
		end else begin
			wb_ack_reg <= wb_req && !wb_ack_reg;
			if (wb_req && !wb_ack_reg) begin
				wb_dat_reg <= rd_word;
			end
		end
	end

	// Writes land on the edge where the master samples ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= CTRL_RST;
			din_function_reg <= DIN_FUNC_RST;
			ain_bias_reg <= BIAS_RST;
			threshold_a_reg <= THRESHOLD_RST;
			ain_lowpass_break_reg <= BREAK_RST;
			ain_current_per_volt_reg <= SCALE_RST;
			ain_velocity_per_volt_reg <= SCALE_RST;
			aout_source_select_reg <= AOUT_SELECT_RST;
			aout_user_value_reg <= AOUT_USER_RST;
			aout_scale_factor_reg <= SCALE_RST;
		end else if (wb_req && wb_we_i && wb_ack_reg) begin
			case (wb_adr_i)
				REG_CTRL_OFS: ctrl_reg <= wr_word[5:0];
				REG_DIN_FUNC_OFS: din_function_reg <= wr_word[24:0];
				REG_AIN_BIAS_OFS: ain_bias_reg <= wr_word[15:0];
				REG_THRESHOLD_A_OFS: threshold_a_reg <= wr_word[15:0];
				REG_AIN_BREAK_OFS: ain_lowpass_break_reg <= wr_word[3:0];
				REG_AIN_CUR_SCALE_OFS: ain_current_per_volt_reg <= wr_word[15:0];
				REG_AIN_VEL_SCALE_OFS: ain_velocity_per_volt_reg <= wr_word[15:0];
				REG_AOUT_SELECT_OFS: aout_source_select_reg <= wr_word[3:0];
				REG_AOUT_USER_OFS: aout_user_value_reg <= wr_word[15:0];
				REG_AOUT_SCALE_OFS: aout_scale_factor_reg <= wr_word[15:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Sampling ticks

	// Hardware tick every 2 us
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			hw_cnt_reg <= 7'h00;
			hw_tick_reg <= 1'b0;
		end else begin
			hw_tick_reg <= (hw_cnt_reg == 7'(HW_TICK_CYCLES - 1));
			hw_cnt_reg <= (hw_cnt_reg == 7'(HW_TICK_CYCLES - 1)) ? 7'h00 : hw_cnt_reg + 7'h01;
		end
	end

	// Software tick every 250 us
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sw_cnt_reg <= '0;
			sw_tick_reg <= 1'b0;
		end else begin
			sw_tick_reg <= (sw_cnt_reg == SW_CNT_W'(SW_TICK_LEN - 1));
			if (sw_cnt_reg == SW_CNT_W'(SW_TICK_LEN - 1)) begin
				sw_cnt_reg <= '0;
			end else begin
				sw_cnt_reg <= sw_cnt_reg + SW_CNT_W'(1);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Digital inputs

	// Fast pair on the hardware tick, slow group held per software tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_din_reg <= 2'h0;
			slow_din_reg <= 5'h00;
		end else begin
			if (hw_tick_reg) begin
				fast_din_reg <= din_i[1:0];
			end
			if (sw_tick_reg) begin
				slow_din_reg <= din_i[6:2];
			end
		end
	end

	// Function activity with polarity set by the function
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			din_func_reg <= 5'h00;
		end else begin
			for (int i = 0; i < 5; i++) begin
				din_func_reg[i] <= (din_function_reg[i] != FUNC_NONE) &&
					(slow_din_reg[i] ^ func_low_active(din_function_reg[i]));
			end
		end
	end

	// Input eight goes straight to the enable gate
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			enable_in_reg <= 1'b0;
			stage_enable_reg <= 1'b0;
		end else begin
			enable_in_reg <= din_i[7];
			stage_enable_reg <= din_i[7] && safe_torque_off_in_i &&
				(ctrl_reg.sw_enable || ctrl_reg.sw_enable_permanent);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog input chain

	// Bias then deadband
	always_comb begin
		biased = sat16(32'(ain_sample_i) + 32'(ain_bias_reg));
		biased_wide = 17'(biased);
		biased_mag = (biased_wide < 0) ? -biased_wide : biased_wide;
		deadbanded = (biased_mag < $signed({1'b0, threshold_a_reg})) ? 16'sh0000 : biased;
	end

	ain_lowpass #(
		.W(DATA_W)
	) ain_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.step_i(sw_tick_reg),
		.shift_i(ain_lowpass_break_reg),
		.x_i(deadbanded),
		.y_o(ain_lp)
	);

	// Commands to the loops, only from the analog source
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ain_filtered_value_reg <= 16'sh0000;
			cmd_valid_reg <= 1'b0;
			current_cmd_reg <= 16'sh0000;
			velocity_cmd_reg <= 16'sh0000;
		end else begin
			ain_filtered_value_reg <= ain_lp;
			cmd_valid_reg <= (ctrl_reg.cmd_source == CMD_SRC_ANALOG);
			current_cmd_reg <= 16'sh0000;
			velocity_cmd_reg <= 16'sh0000;
			if (ctrl_reg.cmd_source == CMD_SRC_ANALOG) begin
				if (ctrl_reg.opmode == OPMODE_CURRENT) begin
					current_cmd_reg <= scale_q8(ain_lp, ain_current_per_volt_reg);
				end else if (ctrl_reg.opmode == OPMODE_VELOCITY) begin
					velocity_cmd_reg <= scale_q8(ain_lp, ain_velocity_per_volt_reg);
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Analog output

	ain_lowpass #(
		.W(DATA_W)
	) vel_filter (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.step_i(sw_tick_reg),
		.shift_i(VEL_SMOOTH_SHIFT),
		.x_i(drive_i.velocity_feedback),
		.y_o(vel_smooth)
	);

	// Triangle stepped on the hardware tick
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tri_dir_reg <= TRI_UP;
			tri_reg <= 16'sh0000;
		end else if (hw_tick_reg) begin
			unique case (tri_dir_reg)
				TRI_UP: begin
					tri_reg <= tri_reg + TRI_STEP;
					if (tri_reg + TRI_STEP >= TRI_PEAK) begin
						tri_dir_reg <= TRI_DOWN;
					end
				end
				TRI_DOWN: begin
					tri_reg <= tri_reg - TRI_STEP;
					if (tri_reg - TRI_STEP <= TRI_TROUGH) begin
						tri_dir_reg <= TRI_UP;
					end
				end
			endcase
		end
	end

	// Source selection
	always_comb begin
		unique case (aout_source_select_reg)
			AOUT_USER: aout_next = aout_user_value_reg;
			AOUT_VEL_FB: aout_next = scale_q8(drive_i.velocity_feedback, aout_scale_factor_reg);
			AOUT_VEL_ERR: aout_next = scale_q8(drive_i.velocity_error, aout_scale_factor_reg);
			AOUT_VEL_CMD: aout_next = scale_q8(drive_i.velocity_command, aout_scale_factor_reg);
			AOUT_CUR_ACT: aout_next = drive_i.current_actual;
			AOUT_CUR_CMD: aout_next = drive_i.current_command;
			AOUT_POS_ACT: aout_next = drive_i.position_actual;
			AOUT_POS_ERR: aout_next = drive_i.position_error;
			AOUT_TRIANGLE: aout_next = tri_reg;
			AOUT_DEBUG: aout_next = debug_vars_i[aout_user_value_reg[1:0]];
			AOUT_VEL_RAW: aout_next = drive_i.velocity_feedback_raw;
			AOUT_VEL_SMOOTH: aout_next = vel_smooth;
			default: aout_next = 16'sh0000;
		endcase
	end

	// Present output value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			aout_reg <= 16'sh0000;
		end else begin
			aout_reg <= aout_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	assign wb_dat_o = wb_dat_reg;
	assign wb_ack_o = wb_ack_reg;
	assign fast_din_o = fast_din_reg;
	assign din_func_active_o = din_func_reg;
	assign stage_enable_o = stage_enable_reg;
	assign cmd_valid_o = cmd_valid_reg;
	assign current_command_o = current_cmd_reg;
	assign velocity_command_o = velocity_cmd_reg;
	assign ain_filtered_value_o = ain_filtered_value_reg;
	assign aout_present_voltage_o = aout_reg;

	////////////////////////////////////////////////////////////////////////////
	// Assertions

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_all_enable;
		din_i[7] && safe_torque_off_in_i && (ctrl_reg.sw_enable || ctrl_reg.sw_enable_permanent);
	endsequence

	AST_STAGE_ON: assert property (s_all_enable |=> stage_enable_o)
		else $error("stage not enabled with all conditions met");
	AST_STAGE_OFF: assert property (!din_i[7] |=> !stage_enable_o)
		else $error("stage enabled while enable input low");
	AST_STAGE_SW: assert property (!(ctrl_reg.sw_enable || ctrl_reg.sw_enable_permanent)
		|=> !stage_enable_o)
		else $error("stage enabled without software enable");
	AST_HW_PERIOD: assert property (hw_tick_reg |-> ##100 hw_tick_reg)
		else $error("hardware tick period wrong");
	AST_FAST_SAMPLE: assert property (hw_tick_reg |=> fast_din_o == $past(din_i[1:0]))
		else $error("fast inputs not sampled on tick");
	AST_SLOW_HOLD: assert property (!sw_tick_reg |=> $stable(slow_din_reg))
		else $error("slow inputs changed between ticks");
	AST_FUNC_NONE: assert property ((din_function_reg[0] == FUNC_NONE) [*2] |-> !din_func_active_o[0])
		else $error("unassigned input reports activity");
	AST_CMD_GATE: assert property (ctrl_reg.cmd_source != CMD_SRC_ANALOG
		|=> !cmd_valid_o && current_command_o == 16'sh0000 && velocity_command_o == 16'sh0000)
		else $error("command driven without analog source");
	AST_AOUT_USER: assert property (aout_source_select_reg == AOUT_USER
		|=> aout_present_voltage_o == $past(aout_user_value_reg))
		else $error("user output value not presented");
endmodule // drive_io_conditioning
`default_nettype wire

// [dv/field_model.sv]
// Field side model: switches, enable wiring and analog command source
`timescale 1ns/1ps
`default_nettype none
module field_model (
	input wire logic [7:0] din_set_i,
	input wire logic sto_set_i,
	input wire logic signed [15:0] ain_set_i,
	output logic [7:0] din_o,
	output logic safe_torque_off_in_o,
	output logic signed [15:0] ain_o
);
	// Switch contacts and the command source follow the bench levels
	assign din_o = din_set_i;
	assign safe_torque_off_in_o = sto_set_i;
	assign ain_o = ain_set_i;
endmodule // field_model
`default_nettype wire

// [dv/drive_io_conditioning_tb.sv]
// Self-checking bench for drive I/O conditioning
`timescale 1ns/1ps
`default_nettype none
module drive_io_conditioning_tb
	import drive_io_pkg::*;
;
	localparam int SWL = 50;
	logic clk, rst, cyc, we, ack, safe_torque_off_in, sto_set, stage, cmd_valid;
	logic [7:0] adr, din_set, din;
	logic [31:0] dat, dat_o, q;
	logic signed [15:0] ain_set, ain, cur, vel, fval, aout;
	logic [1:0] fast;
	logic [4:0] act;
	drive_signals_t drv;
	logic [3:0][15:0] dbg;
	int n_errors = 0, total_checks = 0, seed = 32'h8D15;
	int v[8], usr, b, x, y;

	////////////////////////////////////////////////////////////////
	// Clock
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	// Design and field side
	drive_io_conditioning #(.SW_TICK_LEN(SWL)) dut (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
		.din_i(din), .safe_torque_off_in_i(safe_torque_off_in), .ain_sample_i(ain), .drive_i(drv), .debug_vars_i(dbg),
		.fast_din_o(fast), .din_func_active_o(act), .stage_enable_o(stage), .cmd_valid_o(cmd_valid),
		.current_command_o(cur), .velocity_command_o(vel), .ain_filtered_value_o(fval),
		.aout_present_voltage_o(aout));
	field_model field (.din_set_i(din_set), .sto_set_i(sto_set), .ain_set_i(ain_set), .din_o(din),
		.safe_torque_off_in_o(safe_torque_off_in), .ain_o(ain));

	// Reference for the 10 Hz velocity smoothing, stepped on the software tick
	int sc;
	logic tk;
	longint acc, acc_d;
	always @(posedge clk) begin
		if (rst) begin
			sc <= 0;
			tk <= 1'b0;
			acc <= 0;
			acc_d <= 0;
		end else begin
			tk <= (sc == SWL - 1);
			sc <= (sc == SWL - 1) ? 0 : sc + 1;
			acc_d <= acc;
			if (tk) begin
				acc <= acc + (((longint'(drv.velocity_feedback) <<< 16) - acc) >>> VEL_SMOOTH_SHIFT);
			end
		end
	end

	////////////////////////////////////////////////////////////////
	// Reference model helpers
	function automatic int sat16(input int a);
		return (a > 32767) ? 32767 : ((a < -32768) ? -32768 : a);
	endfunction

	function automatic int aout_exp(input int c);
		case (c)
			0: return usr;
			1, 2, 3: return sat16((v[c - 1] * 512) >>> 8);
			4, 5, 6, 7: return v[c - 1];
			9: return (usr & 3) * 300 + 5;
			10: return v[7];
			11: return int'(acc_d >>> 16);
			default: return 0;
		endcase
	endfunction

	// Compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// Classic single bus cycle, held until ack is sampled
	task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		cyc <= 1'b1;
		adr <= a;
		we <= w;
		dat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n == 50) begin
			n_errors++;
			wrap_up();
		end
		r = dat_o;
		cyc <= 1'b0;
		@(posedge clk);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		wb(a, 1'b0, 32'h0, r);
		check(r, e);
	endtask

	task automatic wrap_up;
		$display("checks=%0d errors=%0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Hang guard
	initial begin
		#400000;
		n_errors++;
		wrap_up();
	end

	// Main sequence
	initial begin
		rst = 1'b1;
		cyc = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		din_set = 8'h00;
		sto_set = 1'b0;
		ain_set = 16'h0000;
		drv = '0;
		dbg = '0;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rc(REG_CTRL_OFS, 32'h0);
		rc(REG_DIN_FUNC_OFS, 32'h0);
		rc(REG_AIN_BREAK_OFS, 32'h4);
		rc(REG_AOUT_SCALE_OFS, 32'h100);
		rc(8'h3C, 32'h0);
		check(act, 5'h00);
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			wb(REG_CTRL_OFS, 1'b1, {30'h0, i[1:0]}, q);
			din_set <= {i[2], 7'h00};
			sto_set <= i[3];
			repeat (3) @(posedge clk);
			check(stage, i[2] & i[3] & (i[0] | i[1]));
		end
		$display("test enable done");
		for (int i = 0; i < 8; i++) begin
			v[i] = $random(seed) % 4000;
			drv[127 - 16 * i -: 16] <= 16'(v[i]);
			if (i < 4) begin
				dbg[i[1:0]] <= 16'(i[1:0] * 300 + 5);
			end
		end
		usr = $random(seed) & 32'h3FFF;
		wb(REG_AOUT_SCALE_OFS, 1'b1, 32'h200, q);
		wb(REG_AOUT_USER_OFS, 1'b1, 32'(usr), q);
		for (int c = 0; c < 16; c++) begin
			wb(REG_AOUT_SELECT_OFS, 1'b1, 32'(c), q);
			repeat (3) @(posedge clk);
			x = aout;
			if (c == 8) begin
				repeat (100) @(posedge clk);
				check(aout - x == 256 || x - aout == 256, 1'b1);
			end else begin
				check(aout, aout_exp(c));
				if (c != 11) begin
					rc(REG_AOUT_PRESENT_VOLTAGE_OFS, {16'h0, 16'(aout_exp(c))});
				end
			end
		end
		$display("test analog output done");
		b = $random(seed) % 500;
		wb(REG_AIN_BREAK_OFS, 1'b1, 32'h0, q);
		wb(REG_THRESHOLD_A_OFS, 1'b1, 32'h12C, q);
		wb(REG_AIN_BIAS_OFS, 1'b1, 32'(b), q);
		wb(REG_AIN_CUR_SCALE_OFS, 1'b1, 32'h180, q);
		wb(REG_AIN_VEL_SCALE_OFS, 1'b1, 32'h180, q);
		for (int i = 0; i < 6; i++) begin
			x = (i == 2) ? 200 - b : $random(seed) % 8000;
			y = sat16(x + b);
			if (y < 300 && y > -300) y = 0;
			ain_set <= 16'(x);
			wb(REG_CTRL_OFS, 1'b1, {26'h0, 1'b0, i[0], 4'hD}, q);
			repeat (2 * SWL + 5) @(posedge clk);
			check(fval, y);
			check(cur, i[0] ? 0 : sat16((y * 384) >>> 8));
			check(vel, i[0] ? sat16((y * 384) >>> 8) : 0);
			check(cmd_valid, 1'b1);
			rc(REG_AIN_FILTERED_VALUE_OFS, {16'h0, 16'(y)});
		end
		wb(REG_CTRL_OFS, 1'b1, 32'h1, q);
		repeat (3) @(posedge clk);
		check({cmd_valid, cur}, 17'h0);
		$display("test analog input done");
		wb(REG_DIN_FUNC_OFS, 1'b1, {22'h0, 5'h01, FUNC_CTRL_STOP}, q);
		din_set <= 8'h02;
		repeat (2 * SWL + 105) @(posedge clk);
		check(act, 5'h01);
		check(fast, 2'h2);
		din_set <= 8'h7D;
		repeat (2 * SWL + 105) @(posedge clk);
		check(act, 5'h02);
		check(fast, 2'h1);
		$display("test digital inputs done");
		wrap_up();
	end
endmodule // drive_io_conditioning_tb
`default_nettype wire
